//--- logic/fmc_map.svh
`ifndef FMC_MAP_SVH
`define FMC_MAP_SVH

// ---------------------------------------------------------------
// Register addresses
// ---------------------------------------------------------------
`define FMC_ADDR_INT    8'h03
`define FMC_ADDR_FRAC   8'h04
`define FMC_ADDR_CFG    8'h06
`define FMC_ADDR_EXACT  8'h1A

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define FMC_CFG_RST     24'h30F0A
`define FMC_INT_RST     19'h00019
`define FMC_FRAC_RST    24'h000000
`define FMC_EXACT_RST   24'h000000

// ---------------------------------------------------------------
// Field positions of the modulator configuration register
// ---------------------------------------------------------------
`define FMC_ORD_LO      2
`define FMC_ORD_HI      3
`define FMC_BIT_SYNC    4
`define FMC_BIT_EXACT   5
`define FMC_BIT_BYPASS  7
`define FMC_BIT_SEED    8
`define FMC_BIT_CORE    11

// ---------------------------------------------------------------
// Widths
// ---------------------------------------------------------------
`define FMC_REG_W       24
`define FMC_INT_W       19
`define FMC_ADDR_W      8
`define FMC_FRAME_W     32

`endif

//--- logic/fmc_pkg.sv
package fmc_pkg;

   // Modulator order codes; the last code is reserved.
   typedef enum logic [1:0] {
      FMC_ORD_FIRST  = 2'h0,
      FMC_ORD_SECOND = 2'h1,
      FMC_ORD_THIRD  = 2'h2,
      FMC_ORD_RSVD   = 2'h3
   } fmc_order_t;

   // One serial frame: address first on the wire, then data.
   typedef struct packed {
      logic [7:0]  addr;
      logic [23:0] data;
   } fmc_frame_t;

endpackage

//--- logic/fmc_shift_if.sv
`timescale 1ns/1ps
interface fmc_shift_if;
   import fmc_pkg::*;

   fmc_frame_t frame;

   modport shifter (output frame);
   modport core    (input  frame);
endinterface

//--- logic/fmc_sync3.sv
`timescale 1ns/1ps
module fmc_sync3
   import fmc_pkg::*;
(
   input  wire logic clk_in,
   input  wire logic rst_in,
   input  wire logic ce_in,
   input  wire logic d_in,
   output logic      level_out,
   output logic      rise_out
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic level_q;
   logic rise_q;
   wire  agree = (s2_q == s3_q);

   // ---------------------------------------------------------------
   // Three-stage retiming; a change counts once stages two and three agree.
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s1_q    <= 1'b0;
         s2_q    <= 1'b0;
         s3_q    <= 1'b0;
         level_q <= 1'b0;
         rise_q  <= 1'b0;
      end else if (ce_in) begin
         s1_q    <= d_in;
         s2_q    <= s1_q;
         s3_q    <= s2_q;
         level_q <= agree ? s3_q : level_q;
         rise_q  <= agree && s3_q && !level_q;
      end
   end

   assign level_out = level_q;
   assign rise_out  = rise_q;
endmodule // fmc_sync3

//--- logic/fmc_shifter.sv
`timescale 1ns/1ps
module fmc_shifter
   import fmc_pkg::*;
(
   input  wire logic   link_clk_in,
   input  wire logic   rst_in,
   input  wire logic   serial_data_in,
   fmc_shift_if.shifter sh
);
   // ---------------------------------------------------------------
   // Shift register on the serial clock; the last 32 bits form the frame.
   // ---------------------------------------------------------------
   // The serial clock may stop between frames, so no frame counter is kept.
   always_ff @(posedge link_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sh.frame <= '0;
      end else begin
         sh.frame <= {sh.frame[$bits(fmc_frame_t)-2:0], serial_data_in};
      end
   end
endmodule // fmc_shifter

//--- logic/fmc_top.sv
`timescale 1ns/1ps
`include "fmc_map.svh"

// Functional notes
// - Bits three-two select modulator order
// - Sync bit clear: load on strobe rise
// - Normal load ignores internal clock, may glitch
// - Sync bit set: defer frequency registers one tick
// - Bit five enables exact-frequency mode
// - Bit seven bypasses modulator into divider
// - Bypassed modulator still clocked if core enabled
// - Seed reload bit set: fraction write reseeds
// - Seed reload clear: modulator keeps phase
// - Bit eleven enables modulator core
// - Configuration register resets to 30F0A
// - Fraction is 24-bit, fractional mode only
module fmc_top
   import fmc_pkg::*;
#(
   parameter int INT_W  = `FMC_INT_W,
   parameter int REG_W  = `FMC_REG_W
) (
   input  wire logic               mclk_in,
   input  wire logic               rst_in,
   input  wire logic               ce_in,
   input  wire logic               link_clk_in,
   input  wire logic               serial_data_in,
   input  wire logic               serial_latch_strobe_in,
   input  wire logic               phase_compare_tick_in,
   output logic [`FMC_REG_W-1:0]   config_out,
   output fmc_order_t              shaper_order_select_out,
   output logic                    order_reserved_out,
   output logic                    sync_load_out,
   output logic                    exact_mode_out,
   output logic                    modulator_bypass_out,
   output logic                    modulator_route_out,
   output logic                    modulator_clk_en_out,
   output logic                    seed_reload_out,
   output logic                    load_pending_out,
   output logic [INT_W-1:0]        int_word_out,
   output logic [REG_W-1:0]        frac_word_out,
   output logic [REG_W-1:0]        frac_active_out,
   output logic [REG_W-1:0]        exact_word_out
);

   // ---------------------------------------------------------------
   // Helper functions
   // ---------------------------------------------------------------
   function automatic logic addr_hit(input fmc_frame_t f,
                                     input logic [`FMC_ADDR_W-1:0] a);
      return (f.addr == a);
   endfunction

   function automatic logic [REG_W-1:0] pick(input logic sel,
                                             input logic [REG_W-1:0] a,
                                             input logic [REG_W-1:0] b);
      return sel ? a : b;
   endfunction

   // Integer words sit zero-extended in a full-width slot.
   function automatic logic [REG_W-1:0] widen_int(input logic [INT_W-1:0] v);
      return {{(REG_W-INT_W){1'b0}}, v};
   endfunction

   // ---------------------------------------------------------------
   // Serial link side
   // ---------------------------------------------------------------
   // The shifter runs on the link clock alone; only the strobe crosses, and the
   // frame word is read once the retimed strobe edge shows it has settled.
   fmc_shift_if shift_bus ();

   fmc_shifter u_shifter (
      .link_clk_in    (link_clk_in),
      .rst_in         (rst_in),
      .serial_data_in (serial_data_in),
      .sh             (shift_bus.shifter)
   );

   logic strobe_rise;

   fmc_sync3 u_strobe_sync (
      .clk_in    (mclk_in),
      .rst_in    (rst_in),
      .ce_in     (ce_in),
      .d_in      (serial_latch_strobe_in),
      .level_out (),
      .rise_out  (strobe_rise)
   );

   // ---------------------------------------------------------------
   // Frame decode
   // ---------------------------------------------------------------
   // The shifter word is sampled only on the retimed strobe edge; the host
   // keeps it still long enough for this crossing to settle.
   fmc_frame_t frame;
   assign frame = shift_bus.frame;

   logic [REG_W-1:0] cfg_q;
   logic             sync_mode;
   logic             seed_enable;
   logic             wr_cfg;
   logic             wr_int;
   logic             wr_frac;
   logic             wr_exact;

   assign sync_mode   = cfg_q[`FMC_BIT_SYNC];
   assign seed_enable = cfg_q[`FMC_BIT_SEED];
   // An unknown address matches no select and the frame is dropped.
   assign wr_cfg      = strobe_rise && addr_hit(frame, `FMC_ADDR_CFG);
   assign wr_int      = strobe_rise && addr_hit(frame, `FMC_ADDR_INT);
   assign wr_frac     = strobe_rise && addr_hit(frame, `FMC_ADDR_FRAC);
   assign wr_exact    = strobe_rise && addr_hit(frame, `FMC_ADDR_EXACT);

   // ---------------------------------------------------------------
   // Load routing: immediate or deferred
   // ---------------------------------------------------------------
   // An immediate load lands with no regard to the compare clock, so a
   // frequency word written this way may step the divider mid-cycle.
   logic now_int;
   logic now_frac;
   logic now_exact;
   logic defer_int;
   logic defer_frac;
   logic defer_exact;

   assign now_int     = wr_int && !sync_mode;
   assign now_frac    = wr_frac && !sync_mode;
   assign now_exact   = wr_exact && !sync_mode;
   assign defer_int   = wr_int && sync_mode;
   assign defer_frac  = wr_frac && sync_mode;
   assign defer_exact = wr_exact && sync_mode;

   // One slot per register; a newer deferred write replaces unapplied data.
   // A mode change does not flush a slot, which still lands on the next tick.
   logic             pend_int_q;
   logic             pend_frac_q;
   logic             pend_exact_q;
   logic [INT_W-1:0] pend_int_data_q;
   logic [REG_W-1:0] pend_frac_data_q;
   logic [REG_W-1:0] pend_exact_data_q;

   logic tick_int;
   logic tick_frac;
   logic tick_exact;

   assign tick_int   = phase_compare_tick_in && pend_int_q;
   assign tick_frac  = phase_compare_tick_in && pend_frac_q;
   assign tick_exact = phase_compare_tick_in && pend_exact_q;

   // A new deferred write in the same cycle as a tick stays pending.
   logic pend_int_d;
   logic pend_frac_d;
   logic pend_exact_d;

   assign pend_int_d   = defer_int || (pend_int_q && !tick_int);
   assign pend_frac_d  = defer_frac || (pend_frac_q && !tick_frac);
   assign pend_exact_d = defer_exact || (pend_exact_q && !tick_exact);

   logic [INT_W-1:0] pend_int_data_d;
   logic [REG_W-1:0] pend_frac_data_d;
   logic [REG_W-1:0] pend_exact_data_d;

   assign pend_int_data_d   = defer_int ? frame.data[INT_W-1:0] : pend_int_data_q;
   assign pend_frac_data_d  = pick(defer_frac, frame.data, pend_frac_data_q);
   assign pend_exact_data_d = pick(defer_exact, frame.data, pend_exact_data_q);

   // ---------------------------------------------------------------
   // Next values of the working registers
   // ---------------------------------------------------------------
   logic [REG_W-1:0] int_q;
   logic [REG_W-1:0] int_d;
   logic [REG_W-1:0] frac_q;
   logic [REG_W-1:0] frac_d;
   logic [REG_W-1:0] exact_q;
   logic [REG_W-1:0] exact_d;
   logic [REG_W-1:0] pend_int_wide;
   logic             frac_apply;
   logic             frac_use;
   logic [1:0]       order_code;

   assign pend_int_wide = widen_int(pend_int_data_q);

   assign int_d   = pick(now_int, widen_int(frame.data[INT_W-1:0]),
                         pick(tick_int, pend_int_wide, int_q));
   assign frac_d  = pick(now_frac, frame.data,
                         pick(tick_frac, pend_frac_data_q, frac_q));
   assign exact_d = pick(now_exact, frame.data,
                         pick(tick_exact, pend_exact_data_q, exact_q));

   assign frac_apply = now_frac || tick_frac;

   // Fraction reaches the divider only when the modulator is in the path.
   assign frac_use = !cfg_q[`FMC_BIT_BYPASS];

   // Code three is passed through as written and flagged for the divider.
   assign order_code = cfg_q[`FMC_ORD_HI:`FMC_ORD_LO];

   // ---------------------------------------------------------------
   // Configuration register
   // ---------------------------------------------------------------
   // Reserved bits are stored as written; the host keeps bits one-zero at zero.
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         cfg_q <= `FMC_CFG_RST;
      end else if (ce_in && wr_cfg) begin
         cfg_q <= frame.data;
      end
   end

   // ---------------------------------------------------------------
   // Pending slots for deferred loads
   // ---------------------------------------------------------------
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         pend_int_q <= 1'b0;
      end else if (ce_in) begin
         pend_int_q <= pend_int_d;
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         pend_frac_q <= 1'b0;
      end else if (ce_in) begin
         pend_frac_q <= pend_frac_d;
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         pend_exact_q <= 1'b0;
      end else if (ce_in) begin
         pend_exact_q <= pend_exact_d;
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         pend_int_data_q <= '0;
      end else if (ce_in) begin
         pend_int_data_q <= pend_int_data_d;
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         pend_frac_data_q <= '0;
      end else if (ce_in) begin
         pend_frac_data_q <= pend_frac_data_d;
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         pend_exact_data_q <= '0;
      end else if (ce_in) begin
         pend_exact_data_q <= pend_exact_data_d;
      end
   end

   // ---------------------------------------------------------------
   // Working frequency registers
   // ---------------------------------------------------------------
   // Each word has its own flop group, so a deferred load touches only its own.
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         int_q <= {{(REG_W-INT_W){1'b0}}, `FMC_INT_RST};
      end else if (ce_in) begin
         int_q <= int_d;
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         frac_q <= `FMC_FRAC_RST;
      end else if (ce_in) begin
         frac_q <= frac_d;
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         exact_q <= `FMC_EXACT_RST;
      end else if (ce_in) begin
         exact_q <= exact_d;
      end
   end

   // ---------------------------------------------------------------
   // Seed reload and effective fraction
   // ---------------------------------------------------------------
   // Without seed reload the accumulator simply carries on from its phase.
   logic             seed_q;
   logic             seed_d;
   logic [REG_W-1:0] frac_active_q;
   logic [REG_W-1:0] frac_active_d;

   assign seed_d        = frac_apply && seed_enable;
   assign frac_active_d = pick(frac_use, frac_d, {REG_W{1'b0}});

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         seed_q <= 1'b0;
      end else if (ce_in) begin
         seed_q <= seed_d;
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         frac_active_q <= '0;
      end else if (ce_in) begin
         frac_active_q <= frac_active_d;
      end
   end

   // ---------------------------------------------------------------
   // Configuration fields
   // ---------------------------------------------------------------
   assign config_out              = cfg_q;
   assign shaper_order_select_out = fmc_order_t'(order_code);
   assign order_reserved_out      = (order_code == FMC_ORD_RSVD);
   assign sync_load_out           = sync_mode;
   assign exact_mode_out          = cfg_q[`FMC_BIT_EXACT];
   assign modulator_bypass_out    = cfg_q[`FMC_BIT_BYPASS];
   assign modulator_route_out     = frac_use;
   assign modulator_clk_en_out    = cfg_q[`FMC_BIT_CORE];

   // ---------------------------------------------------------------
   // Frequency words and load status
   // ---------------------------------------------------------------
   assign seed_reload_out         = seed_q;
   assign load_pending_out        = pend_int_q || pend_frac_q || pend_exact_q;
   assign int_word_out            = int_q[INT_W-1:0];
   assign frac_word_out           = frac_q;
   assign frac_active_out         = frac_active_q;
   assign exact_word_out          = exact_q;

endmodule // fmc_top

//--- dv/fmc_top_assertions.sv
`timescale 1ns/1ps
`include "fmc_map.svh"
module fmc_top_checker
   import fmc_pkg::*;
#(
   parameter int INT_W = 19,
   parameter int REG_W = 24
) (
   input wire logic                   mclk_in,
   input wire logic                   rst_in,
   input wire logic                   ce_in,
   input wire logic                   phase_compare_tick_in,
   input wire logic [`FMC_REG_W-1:0]  config_out,
   input wire fmc_order_t             shaper_order_select_out,
   input wire logic                   order_reserved_out,
   input wire logic                   sync_load_out,
   input wire logic                   exact_mode_out,
   input wire logic                   modulator_bypass_out,
   input wire logic                   modulator_route_out,
   input wire logic                   modulator_clk_en_out,
   input wire logic                   seed_reload_out,
   input wire logic                   load_pending_out,
   input wire logic [REG_W-1:0]       frac_word_out,
   input wire logic [REG_W-1:0]       frac_active_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);

   a_order_field: assert property (shaper_order_select_out == config_out[3:2])
      else $error("order output differs from config field");
   a_order_rsvd: assert property (order_reserved_out == (config_out[3:2] == 2'h3))
      else $error("reserved order flag wrong");
   a_sync_bit: assert property (sync_load_out == config_out[4])
      else $error("sync load output wrong");
   a_exact_bit: assert property (exact_mode_out == config_out[5])
      else $error("exact mode output wrong");
   a_bypass_route: assert property (modulator_bypass_out == config_out[7]
      && modulator_route_out == !config_out[7])
      else $error("bypass or route output wrong");
   a_core_clock: assert property (modulator_clk_en_out == config_out[11])
      else $error("modulator clock enable wrong");
   a_seed_pulse: assert property (seed_reload_out |-> config_out[8] ##1 !seed_reload_out)
      else $error("seed pulse wrong");
   a_defer_tick: assert property ($changed(frac_word_out) && $past(sync_load_out)
      |-> $past(phase_compare_tick_in && ce_in))
      else $error("deferred fraction applied off tick");
   a_active_follow: assert property (!modulator_bypass_out && $past(!modulator_bypass_out)
      |-> frac_active_out == frac_word_out)
      else $error("active fraction not following");
   a_active_zero: assert property (modulator_bypass_out && $past(modulator_bypass_out)
      |-> frac_active_out == '0)
      else $error("active fraction not ignored");

   c_seed: cover property (seed_reload_out);
   c_defer: cover property (load_pending_out && phase_compare_tick_in);
   c_rsvd: cover property (order_reserved_out);
   c_freeze: cover property (!ce_in);
endmodule // fmc_top_checker

bind fmc_top fmc_top_checker #(.INT_W(INT_W), .REG_W(REG_W)) u_fmc_chk (.mclk_in, .rst_in,
   .ce_in, .phase_compare_tick_in, .config_out, .shaper_order_select_out, .order_reserved_out,
   .sync_load_out, .exact_mode_out, .modulator_bypass_out, .modulator_route_out,
   .modulator_clk_en_out, .seed_reload_out, .load_pending_out, .frac_word_out, .frac_active_out);

//--- dv/fmc_host_model.sv
`timescale 1ns/1ps
module fmc_host_model (
   output logic link_clk_out,
   output logic serial_data_out,
   output logic serial_latch_strobe_out
);
   initial begin
      link_clk_out = 1'b0;
      serial_data_out = 1'b0;
      serial_latch_strobe_out = 1'b0;
   end

   // The link clock runs only within a frame; data is inverted once released.
   task automatic send(input logic [7:0] a, input logic [23:0] d);
      logic [31:0] f;
      f = {a, d};
      if (a == 8'h06) f[1:0] = 2'h0;
      #3.3;
      for (int i = 31; i >= 0; i--) begin
         serial_data_out = f[i];
         #7.5 link_clk_out = 1'b1;
         #7.5 link_clk_out = 1'b0;
      end
      serial_data_out = ~f[0];
      #10 serial_latch_strobe_out = 1'b1;
      #200 serial_latch_strobe_out = 1'b0;
      #200;
   endtask
endmodule // fmc_host_model

//--- dv/fmc_top_bench.sv
`timescale 1ns/1ps
`include "fmc_map.svh"
module fmc_top_bench;
   import fmc_pkg::*;
   typedef struct packed {
      logic [23:0] cfg;
      logic [18:0] iw;
      logic [23:0] fw;
      logic [23:0] ew;
      logic        sd;
   } fmc_note_t;

   logic        mclk_in, rst_in, ce_in, tick, tick_en, seed, pend;
   logic [1:0]  tc;
   wire         link_clk, sdata, strobe;
   logic [23:0] cfg, fw, ew;
   logic [18:0] iw;
   logic [90:0] prev;
   logic [31:0] s;
   fmc_note_t   m;
   fmc_note_t   notes[$];
   int          err_count, compares, cycles;

   fmc_host_model i_host (.link_clk_out(link_clk), .serial_data_out(sdata),
      .serial_latch_strobe_out(strobe));

   fmc_top i_dut (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce_in), .link_clk_in(link_clk),
      .serial_data_in(sdata), .serial_latch_strobe_in(strobe), .phase_compare_tick_in(tick),
      .config_out(cfg), .shaper_order_select_out(), .order_reserved_out(), .sync_load_out(),
      .exact_mode_out(), .modulator_bypass_out(), .modulator_route_out(),
      .modulator_clk_en_out(), .seed_reload_out(seed), .load_pending_out(pend),
      .int_word_out(iw), .frac_word_out(fw), .frac_active_out(), .exact_word_out(ew));

   initial begin
      mclk_in = 1'b0;
      forever #10 mclk_in = ~mclk_in;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   task automatic chk(input logic [91:0] got, input logic [91:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic conclude();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // Notes the expected register image, then sends the frame.
   task automatic wr(input logic [7:0] a, input logic [23:0] d);
      m.sd = 1'b0;
      case (a)
         8'h06: m.cfg = d;
         8'h03: m.iw = d[18:0];
         8'h04: begin
            m.fw = d;
            m.sd = m.cfg[8];
         end
         8'h1A: m.ew = d;
         default: ;
      endcase
      if (a inside {8'h03, 8'h04, 8'h06, 8'h1A}) notes.push_back(m);
      i_host.send(a, d);
   endtask

   // ----------------------------------------------------------
   // Stimulus timing and watcher
   // ----------------------------------------------------------
   always @(posedge mclk_in) begin
      #1;
      tc = tc + 2'h1;
      tick = tick_en && tc == 2'h0;
      cycles++;
      if (cycles == 6000) begin
         err_count++;
         conclude();
      end
   end

   always @(negedge mclk_in) begin
      if (!rst_in && ({cfg, iw, fw, ew} !== prev || seed === 1'b1)) begin
         if (notes.size() == 0) chk({cfg, iw, fw, ew, seed}, 'x);
         else chk({cfg, iw, fw, ew, seed}, notes.pop_front());
      end
      prev = {cfg, iw, fw, ew};
   end

   // ----------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------
   initial begin
      rst_in = 1'b1;
      ce_in = 1'b1;
      tick_en = 1'b1;
      tick = 1'b0;
      tc = 2'h0;
      s = 32'hA66FDAF4;
      m = '{`FMC_CFG_RST, `FMC_INT_RST, `FMC_FRAC_RST, `FMC_EXACT_RST, 1'b0};
      repeat (10) @(posedge mclk_in);
      #1 rst_in = 1'b0;
      @(negedge mclk_in);
      chk({cfg, iw, fw, ew, seed}, m);
      $display("test reset done");
      for (int k = 0; k < 4; k++) wr(8'h06, 24'h30F00 | 24'(k << 2));
      $display("test order done");
      s = lfsr(s);
      wr(8'h04, s[23:0]);
      s = lfsr(s);
      wr(8'h03, {5'h00, s[18:0]});
      s = lfsr(s);
      wr(8'h1A, s[23:0]);
      s = lfsr(s);
      wr(8'h05, s[23:0]);
      $display("test normal load done");
      wr(8'h06, 24'h307A8);
      s = lfsr(s);
      wr(8'h04, s[23:0]);
      wr(8'h06, 24'h30E08);
      s = lfsr(s);
      wr(8'h04, s[23:0]);
      $display("test modes done");
      tick_en = 1'b0;
      wr(8'h06, 24'h30F18);
      s = lfsr(s);
      wr(8'h04, s[23:0]);
      @(negedge mclk_in);
      chk(92'(pend), 92'(1));
      tick_en = 1'b1;
      repeat (10) @(negedge mclk_in);
      chk(92'(pend), 92'(0));
      s = lfsr(s);
      wr(8'h03, {5'h00, s[18:0]});
      s = lfsr(s);
      wr(8'h1A, s[23:0]);
      repeat (10) @(negedge mclk_in);
      chk(92'(notes.size()), 92'(0));
      $display("test sync load done");
      @(posedge mclk_in);
      #1 ce_in = 1'b0;
      i_host.send(8'h1A, ~m.ew);
      @(posedge mclk_in);
      #1 ce_in = 1'b1;
      repeat (10) @(negedge mclk_in);
      chk({cfg, iw, fw, ew, seed}, m);
      $display("test freeze done");
      conclude();
   end
endmodule // fmc_top_bench
